// >>> bst_pkg.sv
/*
 * package for the board scan test logic: tap states, opcodes, identity
 * fields and boundary register sizes.
 * assumes nothing of its surroundings; used by bst_tap and the bench.
 */
`default_nettype none
package bst_pkg;
    // one-hot tap controller states
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008, ST_SHDR = 16'h0010, ST_EX1DR = 16'h0020,
        ST_PADR = 16'h0040, ST_EX2DR = 16'h0080, ST_UPDR = 16'h0100,
        ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR = 16'h0800,
        ST_EX1IR = 16'h1000, ST_PAIR = 16'h2000, ST_EX2IR = 16'h4000,
        ST_UPIR = 16'h8000
    } bst_state_t;

    localparam int IR_W = 3;
    localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] OP_SAMPLE = 3'h1;
    localparam logic [IR_W-1:0] OP_IDCODE = 3'h2;
    localparam logic [IR_W-1:0] OP_CLAMP = 3'h3;
    localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
    // capture pattern ends in 01 so a broken chain is visible
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
    localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;

    // identity fields; values are arbitrary
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART = 16'h0abc;
    localparam logic [10:0] ID_MAKER = 11'h055;
    localparam logic [31:0] ID_CODE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    // boundary cells: outputs sit nearest tdi, inputs nearest tdo
    localparam int N_IN = 4;
    localparam int N_OUT = 4;
    localparam int BSR_W = N_IN + N_OUT;
    localparam logic [N_OUT-1:0] PIN_OUT_RESET = 4'h0;
endpackage
`default_nettype wire

// >>> bst_tap.sv
/*
 * board scan test logic: tap controller, instruction register, bypass,
 * identity and boundary registers, all run on the system clock.
 * assumes tck, tms, tdi, trstN and the device pins come from outside and
 * are synchronised here; tck must be well below a quarter of clock.
 */
`default_nettype none
// Functional notes
// - five test pins: mode select, clock, reset, data in, data out.
// - bypass instruction puts one-bit bypass register between tdi and tdo.
// - external test drives device pins from boundary register output latches.
// - sample captures pin inputs while the device keeps working normally.
// - under sample, shifted data may be updated into the output latches.
// - clamp selects bypass while boundary latches keep driving the pins.
// - identity instruction puts identity register between tdi and tdo.
// - identity register loads its fixed code in capture-dr, then shifts out.
// - identity register 32 bits, bit 0 nearest tdo leaves first.
// - identity code holds maker, part number and version fields.
// - trst low forces the tap asynchronously into test-logic-reset.
// - test-logic-reset loads a functional instruction, here identity.
module bst_tap (
    input wire logic clock,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trstN,
    output logic tdo,
    output logic tdoEn,
    input wire logic [bst_pkg::N_IN-1:0] pinIn,
    input wire logic [bst_pkg::N_OUT-1:0] coreOut,
    output logic [bst_pkg::N_OUT-1:0] pinOut
);
    // ----------------------------------------
    // synchronisers and tck edges
    // ----------------------------------------
    logic [2:0] tck_q;
    logic [1:0] tms_q, tdi_q;
    logic [bst_pkg::N_IN-1:0] pinS1_q, pinS2_q;
    logic tckRise, tckFall, tmsS, tdiS;
    // trst low clears the tap at once; release is synchronised so the
    // tap flops never leave reset close to a clock edge
    logic [1:0] trstSync_q;
    logic tapRst;
    always_ff @(posedge clock or posedge rst or negedge trstN) begin
        if (rst || !trstN) begin
            trstSync_q <= 2'h0;
        end else begin
            trstSync_q <= {trstSync_q[0], 1'b1};
        end
    end
    assign tapRst = ~trstSync_q[1];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tck_q <= 3'h0;
            tms_q <= 2'h3;
            tdi_q <= 2'h3;
            pinS1_q <= '0;
            pinS2_q <= '0;
        end else begin
            tck_q <= {tck_q[1:0], tck};
            tms_q <= {tms_q[0], tms};
            tdi_q <= {tdi_q[0], tdi};
            pinS1_q <= pinIn;
            pinS2_q <= pinS1_q;
        end
    end
    // edge detect on second and third stages only
    assign tckRise = tck_q[1] & ~tck_q[2];
    assign tckFall = ~tck_q[1] & tck_q[2];
    assign tmsS = tms_q[1];
    assign tdiS = tdi_q[1];

    // ----------------------------------------
    // tap state machine
    // ----------------------------------------
    bst_pkg::bst_state_t state_q, state_d;

    function automatic bst_pkg::bst_state_t nextState(bst_pkg::bst_state_t s, logic m);
        case (s)
            bst_pkg::ST_RESET: nextState = m ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
            bst_pkg::ST_IDLE: nextState = m ? bst_pkg::ST_SELDR : bst_pkg::ST_IDLE;
            bst_pkg::ST_SELDR: nextState = m ? bst_pkg::ST_SELIR : bst_pkg::ST_CAPDR;
            bst_pkg::ST_CAPDR: nextState = m ? bst_pkg::ST_EX1DR : bst_pkg::ST_SHDR;
            bst_pkg::ST_SHDR: nextState = m ? bst_pkg::ST_EX1DR : bst_pkg::ST_SHDR;
            bst_pkg::ST_EX1DR: nextState = m ? bst_pkg::ST_UPDR : bst_pkg::ST_PADR;
            bst_pkg::ST_PADR: nextState = m ? bst_pkg::ST_EX2DR : bst_pkg::ST_PADR;
            bst_pkg::ST_EX2DR: nextState = m ? bst_pkg::ST_UPDR : bst_pkg::ST_SHDR;
            bst_pkg::ST_UPDR: nextState = m ? bst_pkg::ST_SELDR : bst_pkg::ST_IDLE;
            bst_pkg::ST_SELIR: nextState = m ? bst_pkg::ST_RESET : bst_pkg::ST_CAPIR;
            bst_pkg::ST_CAPIR: nextState = m ? bst_pkg::ST_EX1IR : bst_pkg::ST_SHIR;
            bst_pkg::ST_SHIR: nextState = m ? bst_pkg::ST_EX1IR : bst_pkg::ST_SHIR;
            bst_pkg::ST_EX1IR: nextState = m ? bst_pkg::ST_UPIR : bst_pkg::ST_PAIR;
            bst_pkg::ST_PAIR: nextState = m ? bst_pkg::ST_EX2IR : bst_pkg::ST_PAIR;
            bst_pkg::ST_EX2IR: nextState = m ? bst_pkg::ST_UPIR : bst_pkg::ST_SHIR;
            bst_pkg::ST_UPIR: nextState = m ? bst_pkg::ST_SELDR : bst_pkg::ST_IDLE;
            default: nextState = bst_pkg::ST_RESET;
        endcase
    endfunction

    assign state_d = tckRise ? nextState(state_q, tmsS) : state_q;

    always_ff @(posedge clock or posedge tapRst) begin
        if (tapRst) begin
            state_q <= bst_pkg::ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // instruction register and decode
    // ----------------------------------------
    logic [bst_pkg::IR_W-1:0] irSh_q, irOut_q;
    logic isExtest, isSample, isIdcode, isClamp, isBypass;

    always_ff @(posedge clock or posedge tapRst) begin
        if (tapRst) begin
            irSh_q <= bst_pkg::IR_CAPTURE;
            irOut_q <= bst_pkg::IR_RESET;
        end else if (state_q == bst_pkg::ST_RESET) begin
            irOut_q <= bst_pkg::IR_RESET;
        end else if (tckRise) begin
            case (state_q)
                bst_pkg::ST_CAPIR: irSh_q <= bst_pkg::IR_CAPTURE;
                bst_pkg::ST_SHIR: irSh_q <= {tdiS, irSh_q[bst_pkg::IR_W-1:1]};
                bst_pkg::ST_UPIR: irOut_q <= irSh_q;
                default: irSh_q <= irSh_q;
            endcase
        end
    end

    assign isExtest = irOut_q == bst_pkg::OP_EXTEST;
    assign isSample = irOut_q == bst_pkg::OP_SAMPLE;
    assign isIdcode = irOut_q == bst_pkg::OP_IDCODE;
    assign isClamp = irOut_q == bst_pkg::OP_CLAMP;
    // all-ones and every unassigned code fall through to bypass
    assign isBypass = ~(isExtest | isSample | isIdcode);

    // ----------------------------------------
    // data registers
    // ----------------------------------------
    logic bypass_q;
    logic [31:0] idSh_q;
    logic [bst_pkg::BSR_W-1:0] bsrSh_q;
    logic [bst_pkg::N_OUT-1:0] bsrUpd_q;
    logic capDr, shDr;
    assign capDr = tckRise && state_q == bst_pkg::ST_CAPDR;
    assign shDr = tckRise && state_q == bst_pkg::ST_SHDR;

    always_ff @(posedge clock or posedge tapRst) begin
        if (tapRst) begin
            bypass_q <= 1'b0;
        end else if (capDr) begin
            bypass_q <= 1'b0;
        end else if (shDr && isBypass) begin
            bypass_q <= tdiS;
        end
    end

    always_ff @(posedge clock or posedge tapRst) begin
        if (tapRst) begin
            idSh_q <= bst_pkg::ID_CODE;
        end else if (capDr && isIdcode) begin
            idSh_q <= bst_pkg::ID_CODE;
        end else if (shDr && isIdcode) begin
            idSh_q <= {tdiS, idSh_q[31:1]};
        end
    end

    // boundary cells only take part under extest and sample
    always_ff @(posedge clock or posedge tapRst) begin
        if (tapRst) begin
            bsrSh_q <= '0;
        end else if (capDr && (isSample || isExtest)) begin
            bsrSh_q <= {coreOut, pinS2_q};
        end else if (shDr && (isSample || isExtest)) begin
            bsrSh_q <= {tdiS, bsrSh_q[bst_pkg::BSR_W-1:1]};
        end
    end

    // update latches survive a return to reset so clamp values persist
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bsrUpd_q <= bst_pkg::PIN_OUT_RESET;
        end else if (tckRise && state_q == bst_pkg::ST_UPDR && (isSample || isExtest)) begin
            bsrUpd_q <= bsrSh_q[bst_pkg::BSR_W-1:bst_pkg::N_IN];
        end
    end

    // ----------------------------------------
    // pin drive and tdo
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinOut <= bst_pkg::PIN_OUT_RESET;
        end else if (isExtest || isClamp) begin
            pinOut <= bsrUpd_q;
        end else begin
            pinOut <= coreOut;
        end
    end

    logic shifting, serOut;
    assign shifting = state_q == bst_pkg::ST_SHIR || state_q == bst_pkg::ST_SHDR;
    always_comb begin
        if (state_q == bst_pkg::ST_SHIR) begin
            serOut = irSh_q[0];
        end else if (isIdcode) begin
            serOut = idSh_q[0];
        end else if (isBypass) begin
            serOut = bypass_q;
        end else begin
            serOut = bsrSh_q[0];
        end
    end

    always_ff @(posedge clock or posedge tapRst) begin
        if (tapRst) begin
            tdo <= 1'b0;
            tdoEn <= 1'b0;
        end else if (tckFall) begin
            tdo <= serOut;
            tdoEn <= shifting;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (tapRst);

    a_tms_advance: assert property (
        tckRise && state_q == bst_pkg::ST_RESET && !tmsS |=> state_q == bst_pkg::ST_IDLE)
        else $error("tap did not leave reset on tms low");
    a_tdo_enable: assert property (
        tckFall |=> tdoEn == $past(shifting))
        else $error("tdo enable outside shift states");
    a_reset_instr: assert property (
        state_q == bst_pkg::ST_RESET |=> irOut_q == bst_pkg::OP_IDCODE)
        else $error("reset did not load identity instruction");
    a_bypass_path: assert property (
        tckFall && state_q == bst_pkg::ST_SHDR && isBypass |=> tdo == $past(bypass_q))
        else $error("bypass bit not on tdo");
    a_id_capture: assert property (
        capDr && isIdcode |=> idSh_q == bst_pkg::ID_CODE)
        else $error("identity code not captured");
    a_id_shift: assert property (
        shDr && isIdcode |=> idSh_q[30:0] == $past(idSh_q[31:1]) && idSh_q[31] == $past(tdiS))
        else $error("identity shift order wrong");
    a_sample_capture: assert property (
        capDr && isSample |=> bsrSh_q == $past({coreOut, pinS2_q}))
        else $error("sample capture wrong");
    a_extest_drive: assert property (
        (isExtest || isClamp) ##1 (isExtest || isClamp) |-> pinOut == $past(bsrUpd_q))
        else $error("pins not driven from update latches");
    a_unknown_bypass: assert property (
        irOut_q inside {3'h4, 3'h5, 3'h6, 3'h7} |-> isBypass && !isClamp)
        else $error("unassigned opcode not bypass");
endmodule
`default_nettype wire

// >>> bst_ctl_model.sv
/*
 * model of the board tester at the far end of the test port: drives the
 * test clock, mode select, data in and test reset, and samples data out.
 * assumes a free-running system clock; test clock stands still between ops.
 */
`default_nettype none
module bst_ctl_model (
    input wire logic clock,
    input wire logic tdoLine,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trstN
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // idle levels
    // ----------------------------------------
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trstN = 1'b0; // held in test reset from power-up
    end

    // ----------------------------------------
    // one test clock period of 200 ns
    // ----------------------------------------
    // data out is sampled at the falling edge, before the tap changes it
    task automatic tick(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clock);
        tck <= 1'b1; // mode and data stable across the rise
        repeat (4) @(posedge clock);
        o = tdoLine;
        tck <= 1'b0;
    endtask

    task automatic testReset(input int holdCycles);
        @(posedge clock);
        trstN <= 1'b0; // asynchronous return to test-logic-reset
        repeat (holdCycles) @(posedge clock);
        trstN <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    // from idle or reset: scan n bits through ir or dr, back to idle
    task automatic shiftReg(input logic ir, input int n, input logic [31:0] din,
                            output logic [31:0] dout);
        logic b;
        dout = 32'h0;
        tick(1'b0, 1'b0, b);
        tick(1'b1, 1'b0, b);
        if (ir) begin
            tick(1'b1, 1'b0, b);
        end
        tick(1'b0, 1'b0, b);
        tick(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], b); // lsb first, exit on last bit
            dout[i] = b;
        end
        tick(1'b1, 1'b0, b);
        tick(1'b0, 1'b0, b);
    endtask
endmodule
`default_nettype wire

// >>> bst_tap_tb.sv
/*
 * self-checking bench for the tap: one task per scenario, tester model on
 * the test pins, bench drives the device pins and core outputs.
 * assumes the package opcodes and identity fields as declared.
 */
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module bst_tap_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // clock, reset and wiring
    // ----------------------------------------
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] pinIn = 4'h0;
    logic [3:0] coreOut = 4'h0;
    logic [3:0] pinOut;
    logic tck, tms, tdi, trstN, tdo, tdoEn, tdoLine;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    // released line shows the inverse, so a stale bit cannot pass
    assign tdoLine = tdoEn ? tdo : ~tdo;
    always #12.5 clock = ~clock;

    bst_tap dut (.clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .trstN(trstN), .tdo(tdo), .tdoEn(tdoEn), .pinIn(pinIn), .coreOut(coreOut),
        .pinOut(pinOut));
    bst_ctl_model m (.clock(clock), .tdoLine(tdoLine), .tck(tck), .tms(tms),
        .tdi(tdi), .trstN(trstN));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // tests need about 2050 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic loadIr(input logic [2:0] op);
        logic [31:0] d;
        m.shiftReg(1'b1, 3, {29'h0, op}, d);
    endtask

    task automatic testIdentity();
        logic [31:0] d;
        `CHK(tdoEn, 1'b0)
        m.shiftReg(1'b0, 32, 32'h0, d);
        `CHK(d, 32'h10abc0ab)
        m.shiftReg(1'b1, 3, 32'h7, d);
        `CHK(d[2:0], 3'b001)
        $display("identity test done");
    endtask

    task automatic testBypass();
        logic [31:0] d;
        logic [2:0] ops [4] = '{bst_pkg::OP_BYPASS, 3'h4, 3'h5, 3'h6};
        coreOut <= 4'hc;
        for (int i = 0; i < 4; i++) begin
            loadIr(ops[i]);
            m.shiftReg(1'b0, 8, 32'ha5, d);
            `CHK(d[7:0], 8'h4a)
            `CHK(tdoEn, 1'b0)
            `CHK(pinOut, coreOut)
        end
        $display("bypass test done");
    endtask

    task automatic testSample();
        logic [31:0] d;
        @(posedge clock);
        coreOut <= 4'h6;
        pinIn <= 4'h9;
        loadIr(bst_pkg::OP_SAMPLE);
        m.shiftReg(1'b0, 8, 32'h3c, d);
        `CHK(d[7:0], 8'h69)
        `CHK(pinOut, 4'h6)
        loadIr(bst_pkg::OP_EXTEST);
        repeat (2) @(posedge clock);
        `CHK(pinOut, 4'h3)
        m.shiftReg(1'b0, 8, 32'ha0, d);
        `CHK(d[7:0], 8'h69)
        @(posedge clock);
        `CHK(pinOut, 4'ha)
        coreOut <= 4'hf;
        loadIr(bst_pkg::OP_CLAMP);
        m.shiftReg(1'b0, 8, 32'h5a, d);
        `CHK(d[7:0], 8'hb4)
        `CHK(pinOut, 4'ha)
        $display("sample extest clamp test done");
    endtask

    task automatic testTrst();
        logic [31:0] d;
        m.testReset(3);
        `CHK(tdoEn, 1'b0)
        `CHK(pinOut, 4'hf)
        m.shiftReg(1'b0, 32, 32'h0, d);
        `CHK(d, 32'h10abc0ab)
        $display("test reset test done");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        m.testReset(2);
        testIdentity();
        testBypass();
        testSample();
        testTrst();
        wrap_up();
    end
endmodule
`default_nettype wire
